//--- core/tofi_pkg.sv
// time-of-flight interrupt block: register map, field positions, reset values, states.
// assumes an 8-bit register port and a single core clock shared with the engine.
package tofi_pkg;

    // ******************************************
    // register offsets
    // ******************************************
    localparam logic [7:0] TOFI_OFF_CONTROL = 8'h00;
    localparam logic [7:0] TOFI_OFF_FLAGS = 8'h02;
    localparam logic [7:0] TOFI_OFF_MASK = 8'h03;
    localparam logic [7:0] TOFI_OFF_COARSE_HI = 8'h04;
    localparam logic [7:0] TOFI_OFF_COARSE_LO = 8'h05;
    localparam logic [7:0] TOFI_OFF_REFCLK_HI = 8'h06;
    localparam logic [7:0] TOFI_OFF_REFCLK_LO = 8'h07;

    // ******************************************
    // field positions
    // ******************************************
    localparam int TOFI_BIT_RESULT_READY = 0;
    localparam int TOFI_BIT_COARSE_OVF = 1;
    localparam int TOFI_BIT_REFCLK_OVF = 2;
    localparam int TOFI_BIT_BEGUN = 3;
    localparam int TOFI_BIT_DONE = 4;
    localparam int TOFI_BIT_MEASURE_GO = 0;
    localparam int TOFI_FLAG_W = 5;
    localparam int TOFI_MASK_W = 3;

    // ******************************************
    // reset values
    // ******************************************
    localparam logic [TOFI_FLAG_W-1:0] TOFI_FLAGS_RESET = 5'h00;
    localparam logic [TOFI_MASK_W-1:0] TOFI_MASK_RESET = 3'h7;
    localparam logic [7:0] TOFI_LIMIT_BYTE_RESET = 8'hFF;
    localparam logic [7:0] TOFI_ZERO_BYTE = 8'h00;

    // ******************************************
    // types
    // ******************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tofi_bus_req_t;

    typedef struct packed {
        logic [15:0] coarse;
        logic [15:0] refclk;
    } tofi_counts_t;

    typedef enum logic [2:0] {
        TOFI_IDLE = 3'b001,
        TOFI_ARMED = 3'b010,
        TOFI_RUN = 3'b100
    } tofi_state_t;

    // a counter that skips past its limit still counts as reaching it
    function automatic logic tofi_limit_hit(input logic [15:0] count, input logic [15:0] limit);
        tofi_limit_hit = (count >= limit);
    endfunction : tofi_limit_hit

endpackage : tofi_pkg

//--- core/tofi_limit_cmp.sv
// overflow comparators for the coarse and reference-clock counters.
// assumes counts and limits are stable within the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module tofi_limit_cmp
    import tofi_pkg::*;
(
    input wire tofi_counts_t counts,
    input wire logic [15:0] coarse_limit,
    input wire logic [15:0] refclk_limit,
    output logic coarse_hit,
    output logic refclk_hit
);

    // combinational so the hit is seen in the cycle the limit is reached; meas_abort follows one cycle later
    assign coarse_hit = tofi_limit_hit(counts.coarse, coarse_limit);
    assign refclk_hit = tofi_limit_hit(counts.refclk, refclk_limit);

endmodule : tofi_limit_cmp
`default_nettype wire

//--- core/tofi_irq_ctrl.sv
// interrupt flags, mask, overflow limits and measurement sequencing of a tof converter.
// assumes the measurement engine pulses start_seen and meas_finished for one cycle
// and presents its running counts on counts; the host uses the plain register port.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tofi_irq_ctrl
    import tofi_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic start_seen,
    input wire logic meas_finished,
    input wire tofi_counts_t counts,
    output logic meas_trigger,
    output logic meas_abort,
    output logic meas_busy,
    output logic irq_pin_n
);

    // ******************************************
    // reset release
    // ******************************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ******************************************
    // decode
    // ******************************************
    tofi_bus_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic wr_flags;
    logic wr_mask;
    logic go_write;
    assign wr_flags = req.wr && (req.addr == TOFI_OFF_FLAGS);
    assign wr_mask = req.wr && (req.addr == TOFI_OFF_MASK);
    assign go_write = req.wr && (req.addr == TOFI_OFF_CONTROL) && req.wdata[TOFI_BIT_MEASURE_GO];

    // ******************************************
    // overflow limits
    // ******************************************
    logic [7:0] coarse_limit_high_q;
    logic [7:0] coarse_limit_low_q;
    logic [7:0] refclk_limit_high_q;
    logic [7:0] refclk_limit_low_q;

    // a low coarse byte of one is legal to store; the host is trusted to avoid it
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            coarse_limit_high_q <= TOFI_LIMIT_BYTE_RESET;
            coarse_limit_low_q <= TOFI_LIMIT_BYTE_RESET;
            refclk_limit_high_q <= TOFI_LIMIT_BYTE_RESET;
            refclk_limit_low_q <= TOFI_LIMIT_BYTE_RESET;
        end else if (req.wr) begin
            if (req.addr == TOFI_OFF_COARSE_HI) coarse_limit_high_q <= req.wdata;
            if (req.addr == TOFI_OFF_COARSE_LO) coarse_limit_low_q <= req.wdata;
            if (req.addr == TOFI_OFF_REFCLK_HI) refclk_limit_high_q <= req.wdata;
            if (req.addr == TOFI_OFF_REFCLK_LO) refclk_limit_low_q <= req.wdata;
        end
    end

    logic coarse_hit;
    logic refclk_hit;

    tofi_limit_cmp u_limit_cmp (
        .counts(counts),
        .coarse_limit({coarse_limit_high_q, coarse_limit_low_q}),
        .refclk_limit({refclk_limit_high_q, refclk_limit_low_q}),
        .coarse_hit(coarse_hit),
        .refclk_hit(refclk_hit)
    );

    // ******************************************
    // measurement sequence
    // ******************************************
    tofi_state_t state_q;
    logic ovf_now;
    logic finish_now;
    logic begin_now;
    assign ovf_now = (state_q == TOFI_RUN) && (coarse_hit || refclk_hit);
    assign finish_now = (state_q == TOFI_RUN) && meas_finished && !ovf_now;
    assign begin_now = (state_q == TOFI_ARMED) && start_seen;

    // a new go restarts the sequence even mid-measurement; the old run is dropped
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= TOFI_IDLE;
        end else if (go_write) begin
            state_q <= TOFI_ARMED;
        end else begin
            unique case (state_q)
                TOFI_IDLE: state_q <= TOFI_IDLE;
                TOFI_ARMED: if (begin_now) state_q <= TOFI_RUN;
                TOFI_RUN: if (ovf_now || finish_now) state_q <= TOFI_IDLE;
                default: state_q <= TOFI_IDLE;
            endcase
        end
    end

    logic meas_trigger_q;
    logic meas_abort_q;
    logic meas_busy_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            meas_trigger_q <= 1'b0;
            meas_abort_q <= 1'b0;
            meas_busy_q <= 1'b0;
        end else begin
            meas_trigger_q <= go_write;
            meas_abort_q <= ovf_now && !go_write;
            meas_busy_q <= go_write || begin_now ||
                ((state_q != TOFI_IDLE) && !ovf_now && !finish_now);
        end
    end

    // ******************************************
    // flags and mask
    // ******************************************
    logic [TOFI_FLAG_W-1:0] flags_q;
    logic [TOFI_FLAG_W-1:0] flags_d;
    logic [TOFI_FLAG_W-1:0] flag_set;
    logic [TOFI_MASK_W-1:0] mask_q;

    always_comb begin
        flag_set = '0;
        flag_set[TOFI_BIT_RESULT_READY] = finish_now;
        flag_set[TOFI_BIT_DONE] = finish_now;
        flag_set[TOFI_BIT_BEGUN] = begin_now;
        flag_set[TOFI_BIT_REFCLK_OVF] = ovf_now && refclk_hit;
        flag_set[TOFI_BIT_COARSE_OVF] = ovf_now && coarse_hit;
        if (go_write) begin
            flags_d = TOFI_FLAGS_RESET;
        end else if (wr_flags) begin
            // set beats a same-cycle clear so no event is lost
            flags_d = (flags_q & ~req.wdata[TOFI_FLAG_W-1:0]) | flag_set;
        end else begin
            flags_d = flags_q | flag_set;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_q <= TOFI_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= TOFI_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= req.wdata[TOFI_MASK_W-1:0];
        end
    end

    // a mask write reaches the pin in the same cycle as the mask register itself
    logic [TOFI_MASK_W-1:0] mask_d;
    assign mask_d = wr_mask ? req.wdata[TOFI_MASK_W-1:0] : mask_q;

    // pin follows the next flags and mask so it moves with the registers it reflects
    logic irq_pin_n_q;
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_pin_n_q <= 1'b1;
        end else begin
            irq_pin_n_q <= ~|(flags_d[TOFI_MASK_W-1:0] & mask_d);
        end
    end

    // ******************************************
    // read port
    // ******************************************
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = TOFI_ZERO_BYTE;
        if (req.rd) begin
            unique case (req.addr)
                TOFI_OFF_CONTROL: rdata_d[TOFI_BIT_MEASURE_GO] = (state_q != TOFI_IDLE);
                TOFI_OFF_FLAGS: rdata_d[TOFI_FLAG_W-1:0] = flags_q;
                TOFI_OFF_MASK: rdata_d[TOFI_MASK_W-1:0] = mask_q;
                TOFI_OFF_COARSE_HI: rdata_d = coarse_limit_high_q;
                TOFI_OFF_COARSE_LO: rdata_d = coarse_limit_low_q;
                TOFI_OFF_REFCLK_HI: rdata_d = refclk_limit_high_q;
                TOFI_OFF_REFCLK_LO: rdata_d = refclk_limit_low_q;
                default: rdata_d = TOFI_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= TOFI_ZERO_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign meas_trigger = meas_trigger_q;
    assign meas_abort = meas_abort_q;
    assign meas_busy = meas_busy_q;
    assign irq_pin_n = irq_pin_n_q;

    // ******************************************
    // assertions
    // ******************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_q);

    a_result_ready_set: assert property (
        finish_now && !go_write |=> flags_q[TOFI_BIT_RESULT_READY])
        else $error("result ready flag not set after finish");
    a_done_flag_set: assert property (
        finish_now && !go_write |=> flags_q[TOFI_BIT_DONE] && state_q == TOFI_IDLE)
        else $error("done flag not set after finish");
    a_begun_flag_set: assert property (
        begin_now && !go_write |=> flags_q[TOFI_BIT_BEGUN] && state_q == TOFI_RUN)
        else $error("begun flag not set on start");
    a_refclk_ovf_abort: assert property (
        state_q == TOFI_RUN && refclk_hit && !go_write
        |=> flags_q[TOFI_BIT_REFCLK_OVF] && meas_abort_q && state_q == TOFI_IDLE)
        else $error("refclk overflow did not flag and abort");
    a_coarse_ovf_abort: assert property (
        state_q == TOFI_RUN && coarse_hit && !go_write
        |=> flags_q[TOFI_BIT_COARSE_OVF] && meas_abort_q && state_q == TOFI_IDLE)
        else $error("coarse overflow did not flag and abort");
    a_zero_write_keeps: assert property (
        flags_q[TOFI_BIT_BEGUN] && !go_write && !(wr_flags && req.wdata[TOFI_BIT_BEGUN])
        |=> flags_q[TOFI_BIT_BEGUN])
        else $error("begun flag lost without a one written");
    a_irq_bits_sticky: assert property (
        flags_q[TOFI_BIT_RESULT_READY] && !go_write && !wr_flags
        |=> flags_q[TOFI_BIT_RESULT_READY] [*1] ##1 1)
        else $error("result ready flag dropped on its own");
    a_go_clears_flags: assert property (
        go_write |=> flags_q == TOFI_FLAGS_RESET && state_q == TOFI_ARMED)
        else $error("measure go did not clear flags");
    a_pin_low_enabled: assert property (
        |(flags_q[TOFI_MASK_W-1:0] & mask_q) |-> !irq_pin_n_q)
        else $error("irq pin high with an enabled flag set");
    a_pin_masked_off: assert property (
        !(|(flags_q[TOFI_MASK_W-1:0] & mask_q)) |-> irq_pin_n_q)
        else $error("irq pin low with no enabled flag");
    a_limit_reached: assert property (
        state_q == TOFI_RUN && !go_write &&
        counts.coarse >= {coarse_limit_high_q, coarse_limit_low_q}
        |=> flags_q[TOFI_BIT_COARSE_OVF])
        else $error("coarse limit reached without overflow flag");
    a_coarse_irq_sticky: assert property (
        flags_q[TOFI_BIT_COARSE_OVF] && !go_write && !(wr_flags && req.wdata[TOFI_BIT_COARSE_OVF])
        |=> flags_q[TOFI_BIT_COARSE_OVF])
        else $error("coarse overflow flag dropped without a one written");
    a_done_flag_keeps: assert property (
        flags_q[TOFI_BIT_DONE] && !go_write && !(wr_flags && req.wdata[TOFI_BIT_DONE])
        |=> flags_q[TOFI_BIT_DONE])
        else $error("done flag lost without a one written");
    a_abort_one_pulse: assert property (
        meas_abort_q |=> !meas_abort_q)
        else $error("abort pulse longer than one cycle");
    a_mask_write_lands: assert property (
        wr_mask |=> mask_q == $past(req.wdata[TOFI_MASK_W-1:0]))
        else $error("mask write did not land");
    a_coarse_low_lands: assert property (
        req.wr && req.addr == TOFI_OFF_COARSE_LO |=> coarse_limit_low_q == $past(req.wdata))
        else $error("coarse low limit write did not land");

    c_full_measure: cover property (begin_now ##[1:300] finish_now);
    c_coarse_abort: cover property (state_q == TOFI_RUN && coarse_hit);
    c_set_clear_race: cover property (wr_flags && |flag_set);
    c_masked_flag: cover property (flags_q[TOFI_BIT_RESULT_READY] && !mask_q[0]);

endmodule : tofi_irq_ctrl
`default_nettype wire

//--- bench/tofi_engine_model.sv
// behavioural measurement engine facing the interrupt block.
// assumes one core clock; the engine only runs once armed by meas_trigger.
`timescale 1ns/1ps
`default_nettype none
module tofi_engine_model
    import tofi_pkg::*;
#(
    parameter int START_DLY = 4,
    parameter int RUN_LEN = 250
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic meas_trigger,
    input wire logic meas_abort,
    output logic start_seen,
    output logic meas_finished,
    output tofi_counts_t counts
);
    // ******************************************
    // sequencing: armed, then running
    // ******************************************
    logic [1:0] st_q;
    logic [15:0] cnt_q;

    // counts read zero outside a run so an idle engine never trips a limit
    assign counts = (st_q == 2'h2) ? tofi_counts_t'{coarse: cnt_q, refclk: cnt_q} : '0;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= 2'h0;
            cnt_q <= 16'h0000;
            start_seen <= 1'b0;
            meas_finished <= 1'b0;
        end else begin
            start_seen <= 1'b0;
            meas_finished <= 1'b0;
            if (meas_trigger) begin
                st_q <= 2'h1;
                cnt_q <= 16'h0000;
            end else if (meas_abort) begin
                st_q <= 2'h0;
            end else if (st_q == 2'h1) begin
                cnt_q <= cnt_q + 16'h0001;
                if (cnt_q == 16'(START_DLY)) begin
                    st_q <= 2'h2;
                    cnt_q <= 16'h0000;
                    start_seen <= 1'b1;
                end
            end else if (st_q == 2'h2) begin
                cnt_q <= cnt_q + 16'h0001;
                if (cnt_q == 16'(RUN_LEN)) begin
                    st_q <= 2'h0;
                    meas_finished <= 1'b1;
                end
            end
        end
    end
endmodule : tofi_engine_model
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the interrupt block with an engine model.
// assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tofi_pkg::*;
    logic core_clk;
    logic reset_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic start_seen;
    logic meas_finished;
    tofi_counts_t counts;
    logic meas_trigger;
    logic meas_abort;
    logic meas_busy;
    logic irq_pin_n;
    int error_cnt = 0;
    int tests_run = 0;
    int abort_cnt = 0;
    int trig_cnt = 0;
    // ******************************************
    // tables: offset, reset, write, readback
    // ******************************************
    localparam logic [7:0] REG_ROWS [7][4] = '{'{8'h03, 8'h07, 8'hFD, 8'h05},
        '{8'h04, 8'hFF, 8'h12, 8'h12}, '{8'h05, 8'hFF, 8'h34, 8'h34},
        '{8'h06, 8'hFF, 8'h56, 8'h56}, '{8'h07, 8'hFF, 8'h78, 8'h78},
        '{8'h02, 8'h00, 8'h1F, 8'h00}, '{8'h0F, 8'h00, 8'hAA, 8'h00}};
    // limits hi/lo x2, mask, flags, pin, aborts
    localparam logic [7:0] RUN_ROWS [5][8] = '{
        '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h06, 8'h19, 8'h01, 8'h00},
        '{8'h00, 8'h03, 8'hFF, 8'hFF, 8'h05, 8'h0A, 8'h01, 8'h01},
        '{8'hFF, 8'hFF, 8'h00, 8'h04, 8'h03, 8'h0C, 8'h01, 8'h01},
        '{8'h01, 8'h00, 8'hFF, 8'hFF, 8'h07, 8'h19, 8'h00, 8'h00},
        '{8'hFF, 8'hFF, 8'h01, 8'h00, 8'h07, 8'h19, 8'h00, 8'h00}};

    tofi_irq_ctrl i_tofi_irq_ctrl (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .start_seen(start_seen), .meas_finished(meas_finished),
        .counts(counts), .meas_trigger(meas_trigger), .meas_abort(meas_abort),
        .meas_busy(meas_busy), .irq_pin_n(irq_pin_n));
    tofi_engine_model i_tofi_engine_model (.core_clk(core_clk), .reset_n(reset_n),
        .meas_trigger(meas_trigger), .meas_abort(meas_abort), .start_seen(start_seen),
        .meas_finished(meas_finished), .counts(counts));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (meas_abort === 1'b1) abort_cnt++;
        if (meas_trigger === 1'b1) trig_cnt++;
    end
    // ******************************************
    // tasks
    // ******************************************
    task automatic report_and_stop();
        $display("errors=%0d tests=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk_byte(reg_rdata, exp);
    endtask : rd

    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask : settle

    // bounded wait; a hung engine or block ends the run as a failure
    task automatic run_meas();
        int n;
        n = 0;
        wr(TOFI_OFF_CONTROL, 8'h01);
        settle();
        while (meas_busy !== 1'b0 && n < 400) begin
            settle();
            n++;
        end
        if (n >= 400) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : run_meas
    // ******************************************
    // main sequence
    // ******************************************
    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) settle();
        chk_bit(irq_pin_n, 1'b1);
        chk_bit(meas_busy, 1'b0);
        for (int i = 0; i < 7; i++) begin
            rd(REG_ROWS[i][0], REG_ROWS[i][1]);
            wr(REG_ROWS[i][0], REG_ROWS[i][2]);
            rd(REG_ROWS[i][0], REG_ROWS[i][3]);
        end
        for (int k = 0; k < 5; k++) begin
            wr(TOFI_OFF_COARSE_HI, RUN_ROWS[k][0]);
            wr(TOFI_OFF_COARSE_LO, RUN_ROWS[k][1]);
            wr(TOFI_OFF_REFCLK_HI, RUN_ROWS[k][2]);
            wr(TOFI_OFF_REFCLK_LO, RUN_ROWS[k][3]);
            wr(TOFI_OFF_MASK, RUN_ROWS[k][4]);
            abort_cnt = 0;
            trig_cnt = 0;
            run_meas();
            rd(TOFI_OFF_FLAGS, RUN_ROWS[k][5]);
            chk_bit(irq_pin_n, RUN_ROWS[k][6][0]);
            chk_byte(8'(abort_cnt), RUN_ROWS[k][7]);
            chk_byte(8'(trig_cnt), 8'h01);
            if (k == 0) begin
                wr(TOFI_OFF_FLAGS, 8'h00);
                rd(TOFI_OFF_FLAGS, 8'h19);
                wr(TOFI_OFF_FLAGS, 8'h08);
                rd(TOFI_OFF_FLAGS, 8'h11);
            end
            wr(TOFI_OFF_MASK, 8'h07);
            settle();
            chk_bit(irq_pin_n, 1'b0);
            wr(TOFI_OFF_FLAGS, 8'h1F);
            settle();
            chk_bit(irq_pin_n, 1'b1);
            rd(TOFI_OFF_FLAGS, 8'h00);
        end
        run_meas();
        wr(TOFI_OFF_CONTROL, 8'h01);
        rd(TOFI_OFF_FLAGS, 8'h00);
        chk_bit(irq_pin_n, 1'b1);
        rd(TOFI_OFF_CONTROL, 8'h01);
        // second reset while a measurement is armed or running
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) settle();
        chk_bit(irq_pin_n, 1'b1);
        chk_bit(meas_busy, 1'b0);
        rd(TOFI_OFF_CONTROL, 8'h00);
        rd(TOFI_OFF_FLAGS, 8'h00);
        rd(TOFI_OFF_MASK, 8'h07);
        rd(TOFI_OFF_REFCLK_HI, 8'hFF);
        rd(TOFI_OFF_COARSE_LO, 8'hFF);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
